// file: rtl/sg_sound_gen.sv
// Sound generator control: AXI4-Lite registers, clock select, tone and duration engine
module sg_sound_gen
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic internal_osc_tick,
	input wire logic low_speed_osc_tick,
	input wire logic high_speed_osc_tick,
	input wire logic external_clock_tick,
	input wire logic debug_mode,
	output logic sound_out,
	output logic sound_out_inv,
	output logic irq
);
	// ****************************************
	// Bus slave
	// ****************************************
	logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	wire wr_fire = aw_full_r && w_full_r && !bvalid_r;
	wire rd_fire = s_axi_arvalid && s_axi_arready;
	wire wr_clk = wr_fire && awaddr_r == sg_pkg::ADDR_CLK_CTRL;
	wire wr_mode = wr_fire && awaddr_r == sg_pkg::ADDR_MODE_SEL;
	wire wr_ctrl = wr_fire && awaddr_r == sg_pkg::ADDR_CONTROL;
	wire wr_buf_any = wr_fire && awaddr_r == sg_pkg::ADDR_BUF_DATA;
	wire wr_buf = wr_buf_any && wstrb_r[1:0] == 2'h3;
	wire wr_flags = wr_fire && awaddr_r == sg_pkg::ADDR_INT_FLAGS;
	wire wr_ie = wr_fire && awaddr_r == sg_pkg::ADDR_INT_EN;
	wire wr_known = wr_clk | wr_mode | wr_ctrl | wr_buf_any | wr_flags | wr_ie;
	assign s_axi_awready = !aw_full_r && !bvalid_r;
	assign s_axi_wready = !w_full_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			bvalid_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bresp_r <= sg_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_full_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_full_r <= 1'b0;
			if (wr_fire)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_known ? sg_pkg::RESP_OKAY : sg_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	logic run_in_debug_r, unit_enable_r, pin_drive_mode_r;
	logic [2:0] clock_divide_select_r;
	logic [1:0] clock_source_select_r, output_mode_select_r, int_enable_r;
	logic [3:0] tempo_duration_select_r;
	logic [15:0] buf_r;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			run_in_debug_r <= 1'b0;
			clock_divide_select_r <= 3'h0;
			clock_source_select_r <= 2'h0;
			tempo_duration_select_r <= 4'h0;
			pin_drive_mode_r <= 1'b0;
			output_mode_select_r <= 2'h0;
			unit_enable_r <= 1'b0;
			int_enable_r <= 2'h0;
			buf_r <= sg_pkg::BUF_RESET;
		end
		else
		begin
			if (wr_clk && !unit_enable_r)
			begin
				run_in_debug_r <= wdata_r[sg_pkg::BIT_RUN_DEBUG];
				clock_divide_select_r <= wdata_r[sg_pkg::BIT_DIV_LO +: 3];
				clock_source_select_r <= wdata_r[sg_pkg::BIT_SRC_LO +: 2];
			end
			if (wr_mode)
			begin
				tempo_duration_select_r <= wdata_r[sg_pkg::BIT_TEMPO_LO +: 4];
				pin_drive_mode_r <= wdata_r[sg_pkg::BIT_DRIVE];
				output_mode_select_r <= wdata_r[sg_pkg::BIT_MODE_LO +: 2];
			end
			if (wr_ctrl)
				unit_enable_r <= wdata_r[sg_pkg::BIT_ENABLE];
			if (wr_ie)
				int_enable_r <= wdata_r[1:0];
			if (wr_buf)
				buf_r <= wdata_r[15:0];
		end
	end

	// ****************************************
	// Sound clock selection and division
	// ****************************************
	logic [8:0] div_cnt_r;
	logic src_tick;
	always_comb
	begin
		case (sg_pkg::sg_src_t'(clock_source_select_r))
			sg_pkg::SRC_INTERNAL: src_tick = internal_osc_tick;
			sg_pkg::SRC_LOW_SPEED: src_tick = low_speed_osc_tick;
			sg_pkg::SRC_HIGH_SPEED: src_tick = high_speed_osc_tick;
			default: src_tick = external_clock_tick;
		endcase
	end
	wire slow_src = clock_source_select_r[0];
	wire [9:0] div_ratio = 10'(sg_pkg::DIV_BASE << clock_divide_select_r);
	wire [8:0] div_last = 9'(div_ratio - 10'h001);
	wire div_ok = slow_src ? clock_divide_select_r == sg_pkg::DIV_UNDIVIDED
		: clock_divide_select_r <= sg_pkg::DIV_LAST_CODE;
	wire clk_run = unit_enable_r && (!debug_mode || run_in_debug_r);
	wire src_gate = clk_run && div_ok && src_tick;
	wire div_wrap = slow_src || div_cnt_r >= div_last;
	wire stick = src_gate && div_wrap;

	always_ff @(posedge clock)
	begin
		if (!rst_n || !unit_enable_r)
			div_cnt_r <= 9'h000;
		else if (src_gate)
			div_cnt_r <= div_wrap ? 9'h000 : 9'(div_cnt_r + 9'h001);
	end

	// ****************************************
	// Sound engine
	// ****************************************
	sg_pkg::sg_state_t state_r, state_nxt;
	logic [15:0] snd_r;
	logic buf_full_r, stop_r, empty_flag_r, done_flag_r, irq_r;
	logic [7:0] tone_cnt_r;
	logic [19:0] dur_cnt_r;
	wire mode_normal = output_mode_select_r == sg_pkg::MODE_NORMAL;
	wire mode_one_shot = output_mode_select_r == sg_pkg::MODE_ONE_SHOT;
	wire mode_melody = output_mode_select_r == sg_pkg::MODE_MELODY;
	wire playing = state_r != sg_pkg::ST_IDLE;
	wire [5:0] snd_len = snd_r[sg_pkg::BIT_LEN_LO +: 6];
	wire [7:0] pitch = mode_melody ? snd_r[7:0] : {2'h0, snd_r[5:0]};
	wire [11:0] len_units = mode_melody ? 12'({1'b0, snd_len} + 7'h01) : 12'h001;
	wire [11:0] units = 12'(len_units * 12'({1'b0, tempo_duration_select_r} + 5'h01));
	wire [19:0] dur_last = 20'((21'(units) << sg_pkg::SHIFT_64TH) - 21'h000001);
	wire dur_end = dur_cnt_r == dur_last;
	wire stop_wr = wr_ctrl && wdata_r[sg_pkg::BIT_STOP];
	wire load = stick && buf_full_r && !stop_r
		&& (!playing || mode_normal || (mode_melody && dur_end));
	wire finish = stick && playing && (stop_r || (!mode_normal && dur_end && !load));
	wire tone_wrap = tone_cnt_r >= pitch;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			sg_pkg::ST_IDLE: if (load) state_nxt = sg_pkg::ST_PLAY;
			// Finish first: a stop that lands on a sound tick ends at once
			sg_pkg::ST_PLAY: if (finish) state_nxt = sg_pkg::ST_IDLE;
				else if (stop_r) state_nxt = sg_pkg::ST_STOP;
			sg_pkg::ST_STOP: if (finish) state_nxt = sg_pkg::ST_IDLE;
			default: state_nxt = sg_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_r <= sg_pkg::ST_IDLE;
			snd_r <= sg_pkg::BUF_RESET;
			buf_full_r <= 1'b0;
			stop_r <= 1'b0;
			tone_cnt_r <= 8'h00;
			dur_cnt_r <= 20'h00000;
		end
		else
		begin
			state_r <= state_nxt;
			if (load)
				snd_r <= buf_r;
			if (wr_buf)
				buf_full_r <= 1'b1;
			else if (load)
				buf_full_r <= 1'b0;
			if (stop_wr)
				stop_r <= 1'b1;
			else if (stick && (finish || !playing))
				stop_r <= 1'b0;
			if (load || finish)
				tone_cnt_r <= 8'h00;
			else if (stick)
				tone_cnt_r <= tone_wrap ? 8'h00 : 8'(tone_cnt_r + 8'h01);
			if (load || finish)
				dur_cnt_r <= 20'h00000;
			else if (stick && playing)
				dur_cnt_r <= dur_end ? 20'h00000 : 20'(dur_cnt_r + 20'h00001);
		end
	end

	// ****************************************
	// Flags and interrupt request
	// ****************************************
	wire irq_cause = |({empty_flag_r, done_flag_r} & int_enable_r);
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			empty_flag_r <= 1'b1;
			done_flag_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			if (load || stop_wr)
				empty_flag_r <= 1'b1;
			else if (wr_buf)
				empty_flag_r <= 1'b0;
			if (finish)
				done_flag_r <= 1'b1;
			else if (wr_buf || (wr_flags && wdata_r[sg_pkg::BIT_DONE]))
				done_flag_r <= 1'b0;
			irq_r <= irq_cause;
		end
	end
	assign irq = irq_r;

	// ****************************************
	// Pin drive
	// ****************************************
	wire in_break = !snd_r[sg_pkg::BIT_TIE] && dur_cnt_r < 20'(sg_pkg::BREAK_TICKS);
	wire rest = mode_melody && snd_r[sg_pkg::BIT_REST];
	wire wave = tone_cnt_r < 8'(snd_len) || (mode_melody && tone_cnt_r < 8'(pitch >> 1));
	wire tone_on = state_r == sg_pkg::ST_PLAY && !rest && !(mode_melody && in_break) && wave;
	logic out_r, out_inv_r;
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			out_r <= 1'b0;
			out_inv_r <= 1'b0;
		end
		else
		begin
			out_r <= tone_on;
			out_inv_r <= pin_drive_mode_r ? (playing && !tone_on) : (playing && rest);
		end
	end
	assign sound_out = out_r;
	assign sound_out_inv = out_inv_r;

	// ****************************************
	// Read mux
	// ****************************************
	logic [31:0] rd_val;
	logic rd_hit;
	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			sg_pkg::ADDR_CLK_CTRL: rd_val = 32'({run_in_debug_r, 1'b0, clock_divide_select_r,
				2'h0, clock_source_select_r});
			sg_pkg::ADDR_MODE_SEL: rd_val = 32'({tempo_duration_select_r, 5'h00,
				pin_drive_mode_r, output_mode_select_r});
			sg_pkg::ADDR_CONTROL: rd_val = 32'({stop_r, 7'h00, unit_enable_r});
			sg_pkg::ADDR_BUF_DATA: rd_val = 32'(buf_r);
			sg_pkg::ADDR_INT_FLAGS: rd_val = 32'({playing, 6'h00, empty_flag_r, done_flag_r});
			sg_pkg::ADDR_INT_EN: rd_val = 32'(int_enable_r);
			default: rd_hit = 1'b0;
		endcase
	end
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= sg_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= rd_hit ? sg_pkg::RESP_OKAY : sg_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_empty_on_load: assert property (load |=> empty_flag_r && playing)
		else $error("load did not set empty and busy");
	a_empty_clear: assert property (wr_buf && !load |=> !empty_flag_r)
		else $error("buffer write did not clear empty flag");
	a_done_on_finish: assert property (finish |=> done_flag_r && !playing)
		else $error("finish did not set done flag");
	a_done_clear: assert property (wr_flags && wdata_r[sg_pkg::BIT_DONE] && !finish
		|=> !done_flag_r)
		else $error("done flag not cleared by write one");
	a_empty_on_stop: assert property (stop_wr |=> empty_flag_r)
		else $error("stop write did not set empty flag");
	a_irq_level: assert property ((empty_flag_r && int_enable_r[1]) |=> irq)
		else $error("irq missing for enabled flag");
	a_irq_done: assert property ((done_flag_r && int_enable_r[0]) |=> irq)
		else $error("irq missing for enabled done flag");
	a_irq_cause: assert property (irq |-> $past(irq_cause))
		else $error("irq without enabled flag");
	a_clk_locked: assert property (wr_clk && unit_enable_r |=> $stable(clock_source_select_r)
		&& $stable(clock_divide_select_r) && $stable(run_in_debug_r))
		else $error("clock control changed while enabled");
	a_clk_gate: assert property ((!unit_enable_r || (debug_mode && !run_in_debug_r)) |-> !stick)
		else $error("sound clock ran while stopped");
	a_narrow_ignored: assert property (wr_buf_any && wstrb_r[1:0] != 2'h3 |=> $stable(buf_r))
		else $error("narrow buffer write took effect");
	a_stop_ends: assert property (stop_r && playing && stick |=> !playing ##1 (!stop_r)[*2])
		else $error("stop did not end output");
	c_one_shot: cover property (mode_one_shot && finish);
	c_melody_chain: cover property (mode_melody && load && playing);
	c_stop_normal: cover property (mode_normal && stop_r && finish);
	c_debug_hold: cover property (playing && debug_mode && !run_in_debug_r);
endmodule

// file: rtl/sg_pkg.sv
// Constants and types shared by the sound generator control block
package sg_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CLK_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE_SEL = 8'h04;
	localparam logic [7:0] ADDR_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_BUF_DATA = 8'h0C;
	localparam logic [7:0] ADDR_INT_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_INT_EN = 8'h14;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_RUN_DEBUG = 8;
	localparam int BIT_DIV_LO = 4;
	localparam int BIT_SRC_LO = 0;
	localparam int BIT_TEMPO_LO = 8;
	localparam int BIT_DRIVE = 2;
	localparam int BIT_MODE_LO = 0;
	localparam int BIT_STOP = 8;
	localparam int BIT_ENABLE = 0;
	localparam int BIT_TIE = 15;
	localparam int BIT_REST = 14;
	localparam int BIT_LEN_LO = 8;
	localparam int BIT_BUSY = 8;
	localparam int BIT_EMPTY = 1;
	localparam int BIT_DONE = 0;
	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [15:0] BUF_RESET = 16'h00FF;
	localparam logic [2:0] DIV_LAST_CODE = 3'h5;
	localparam logic [2:0] DIV_UNDIVIDED = 3'h7;
	localparam logic [9:0] DIV_BASE = 10'h010;
	localparam logic [8:0] TICKS_PER_64TH = 9'h000;
	localparam int SHIFT_64TH = 9;
	localparam logic [4:0] BREAK_TICKS = 5'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SRC_INTERNAL = 2'h0, SRC_LOW_SPEED = 2'h1,
		SRC_HIGH_SPEED = 2'h2, SRC_EXTERNAL = 2'h3} sg_src_t;
	typedef enum logic [1:0] {MODE_NORMAL = 2'h0, MODE_ONE_SHOT = 2'h1,
		MODE_MELODY = 2'h2, MODE_RESERVED = 2'h3} sg_mode_t;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_PLAY = 2'h1, ST_STOP = 2'h3} sg_state_t;
endpackage

// file: dv/sg_buzzer_model.sv
// Buzzer model counting drive activity on the two output pins
module sg_buzzer_model
(
	input wire logic clock,
	input wire logic clear,
	input wire logic pin_pos,
	input wire logic pin_neg,
	output logic [15:0] edge_count,
	output logic [15:0] neg_high_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_pos;
	// ****************************************
	// Counters
	// ****************************************
	always @(posedge clock)
	begin
		last_pos <= pin_pos;
		if (clear)
		begin
			edge_count <= 16'h0000;
			neg_high_count <= 16'h0000;
		end
		else
		begin
			if (pin_pos && !last_pos)
				edge_count <= edge_count + 16'h0001;
			if (pin_neg)
				neg_high_count <= neg_high_count + 16'h0001;
		end
	end
endmodule

// file: dv/tb_sound_generator_control.sv
// Self-checking testbench for the sound generator control block
module tb_sound_generator_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst_n, clr, dbg, tick, tick_slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sound_out, sound_out_inv, irq;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] edges, neg_high;
	logic [7:0] reg_addr [6];
	logic [15:0] reg_exp [6];
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	longint t0;
	sg_sound_gen u_sg_sound_gen (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .internal_osc_tick(tick), .low_speed_osc_tick(tick_slow),
		.high_speed_osc_tick(tick), .external_clock_tick(tick), .debug_mode(dbg),
		.sound_out(sound_out), .sound_out_inv(sound_out_inv), .irq(irq));
	sg_buzzer_model u_sg_buzzer_model (.clock(clock), .clear(clr), .pin_pos(sound_out),
		.pin_neg(sound_out_inv), .edge_count(edges), .neg_high_count(neg_high));
	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic poll(input logic [7:0] a, input logic [15:0] m, input logic [15:0] v);
		int n;
		n = 0;
		do
		begin
			rd_reg(a);
			n++;
		end
		while ((rd[15:0] & m) !== v && n < 4000);
		check(rd[15:0] & m, v);
	endtask
	task automatic check_span(input longint lo, input longint hi);
		longint dur;
		dur = ($time - t0) / 50;
		check({15'h0000, dur >= lo && dur <= hi}, 16'h0001);
	endtask
	task automatic finish_test();
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_values();
		reg_addr = '{sg_pkg::ADDR_CLK_CTRL, sg_pkg::ADDR_MODE_SEL, sg_pkg::ADDR_CONTROL,
			sg_pkg::ADDR_BUF_DATA, sg_pkg::ADDR_INT_FLAGS, sg_pkg::ADDR_INT_EN};
		reg_exp = '{16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0002, 16'h0000};
		for (int i = 0; i < 6; i++)
		begin
			rd_reg(reg_addr[i]);
			check(rd[15:0], reg_exp[i]);
		end
		check({15'h0000, irq}, 16'h0000);
		rd_reg(8'h18);
		check({14'h0000, rsp}, {14'h0000, sg_pkg::RESP_SLVERR});
		wr(8'h18, 16'h1234, 4'hF);
		check({14'h0000, rsp}, {14'h0000, sg_pkg::RESP_SLVERR});
	endtask
	task automatic t_clock_lock();
		wr(sg_pkg::ADDR_CLK_CTRL, 16'h0100, 4'hF);
		wr(sg_pkg::ADDR_CONTROL, 16'h0001, 4'hF);
		wr(sg_pkg::ADDR_CLK_CTRL, 16'h0073, 4'hF);
		rd_reg(sg_pkg::ADDR_CLK_CTRL);
		check(rd[15:0], 16'h0100);
	endtask
	task automatic t_narrow_write();
		wr(sg_pkg::ADDR_BUF_DATA, 16'h0120, 4'h1);
		rd_reg(sg_pkg::ADDR_BUF_DATA);
		check(rd[15:0], 16'h00FF);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0], 16'h0002);
	endtask
	task automatic t_one_shot();
		dbg <= 1'b1;
		wr(sg_pkg::ADDR_INT_EN, 16'h0001, 4'hF);
		wr(sg_pkg::ADDR_MODE_SEL, 16'h0005, 4'hF);
		clr <= 1'b1;
		wr(sg_pkg::ADDR_BUF_DATA, 16'h0804, 4'hF);
		clr <= 1'b0;
		poll(sg_pkg::ADDR_INT_FLAGS, 16'h0100, 16'h0100);
		check(rd[15:0] & 16'h0002, 16'h0002);
		t0 = $time;
		poll(sg_pkg::ADDR_INT_FLAGS, 16'h0100, 16'h0000);
		check_span(8170, 8215);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0], 16'h0003);
		check({15'h0000, irq}, 16'h0001);
		check({15'h0000, edges != 16'h0000}, 16'h0001);
		wr(sg_pkg::ADDR_INT_FLAGS, 16'h0001, 4'hF);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0], 16'h0002);
		check({15'h0000, irq}, 16'h0000);
		dbg <= 1'b0;
	endtask
	task automatic t_stop();
		wr(sg_pkg::ADDR_CONTROL, 16'h0000, 4'hF);
		wr(sg_pkg::ADDR_CLK_CTRL, 16'h0000, 4'hF);
		wr(sg_pkg::ADDR_CONTROL, 16'h0001, 4'hF);
		wr(sg_pkg::ADDR_MODE_SEL, 16'h0000, 4'hF);
		clr <= 1'b1;
		wr(sg_pkg::ADDR_BUF_DATA, 16'h0402, 4'hF);
		clr <= 1'b0;
		poll(sg_pkg::ADDR_INT_FLAGS, 16'h0100, 16'h0100);
		dbg <= 1'b1;
		wr(sg_pkg::ADDR_CONTROL, 16'h0101, 4'hF);
		repeat (40) @(posedge clock);
		rd_reg(sg_pkg::ADDR_CONTROL);
		check(rd[15:0], 16'h0101);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0], 16'h0102);
		check(neg_high, 16'h0000);
		dbg <= 1'b0;
		poll(sg_pkg::ADDR_CONTROL, 16'h0101, 16'h0001);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0] & 16'h0101, 16'h0001);
	endtask
	task automatic t_melody();
		wr(sg_pkg::ADDR_INT_FLAGS, 16'h0001, 4'hF);
		wr(sg_pkg::ADDR_MODE_SEL, 16'h0006, 4'hF);
		wr(sg_pkg::ADDR_INT_EN, 16'h0002, 4'hF);
		wr(sg_pkg::ADDR_BUF_DATA, 16'h0030, 4'hF);
		poll(sg_pkg::ADDR_INT_FLAGS, 16'h0100, 16'h0100);
		t0 = $time;
		wr(sg_pkg::ADDR_BUF_DATA, 16'h8030, 4'hF);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0] & 16'h0002, 16'h0000);
		check({15'h0000, irq}, 16'h0000);
		poll(sg_pkg::ADDR_INT_FLAGS, 16'h0002, 16'h0002);
		check_span(8170, 8215);
		check({15'h0000, irq}, 16'h0001);
		poll(sg_pkg::ADDR_INT_FLAGS, 16'h0101, 16'h0001);
		check({15'h0000, neg_high != 16'h0000}, 16'h0001);
		wr(sg_pkg::ADDR_INT_EN, 16'h0000, 4'hF);
	endtask
	task automatic t_source_select();
		wr(sg_pkg::ADDR_CONTROL, 16'h0000, 4'hF);
		wr(sg_pkg::ADDR_CLK_CTRL, 16'h0001, 4'hF);
		wr(sg_pkg::ADDR_CONTROL, 16'h0001, 4'hF);
		wr(sg_pkg::ADDR_MODE_SEL, 16'h0001, 4'hF);
		wr(sg_pkg::ADDR_BUF_DATA, 16'h0404, 4'hF);
		repeat (100) @(posedge clock);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0] & 16'h0100, 16'h0000);
		wr(sg_pkg::ADDR_CONTROL, 16'h0000, 4'hF);
		wr(sg_pkg::ADDR_CLK_CTRL, 16'h0071, 4'hF);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0] & 16'h0100, 16'h0000);
		tick_slow <= 1'b0;
		wr(sg_pkg::ADDR_CONTROL, 16'h0001, 4'hF);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0] & 16'h0100, 16'h0000);
		tick_slow <= 1'b1;
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		rd_reg(sg_pkg::ADDR_INT_FLAGS);
		check(rd[15:0] & 16'h0100, 16'h0100);
		wr(sg_pkg::ADDR_CONTROL, 16'h0101, 4'hF);
		poll(sg_pkg::ADDR_CONTROL, 16'h0100, 16'h0000);
	endtask
	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 90000)
		begin
			n_errors++;
			$display("Error at %0t: timeout", $time);
			finish_test();
		end
	end
	initial
	begin
		rst_n = 1'b0;
		clr = 1'b1;
		dbg = 1'b0;
		tick = 1'b1;
		tick_slow = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		clr <= 1'b0;
		t_reset_values();
		t_clock_lock();
		t_narrow_write();
		t_one_shot();
		t_stop();
		t_melody();
		t_source_select();
		finish_test();
	end
endmodule
